// *** mcfg_defines.svh ***
// Offsets, field positions, reset values and timing counts of the start-up configuration bank.
`ifndef MCFG_DEFINES_SVH
`define MCFG_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MCFG_ADVANCE_OFS   8'h22
`define MCFG_SPEEDDET_OFS  8'h23
`define MCFG_OPENLOOP_OFS  8'h24
`define MCFG_STARTUP_OFS   8'h25
`define MCFG_HANDOVER_OFS  8'h26
`define MCFG_FAULT_OFS     8'h27

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MCFG_ADVANCE_RST   8'h00
`define MCFG_SPEEDDET_RST  8'h00
`define MCFG_OPENLOOP_RST  8'h00
`define MCFG_STARTUP_RST   8'h00
`define MCFG_HANDOVER_RST  8'h00
`define MCFG_FAULT_RST     8'h00

// ----------------------------------------
// Field positions (least significant bit)
// ----------------------------------------
`define MCFG_ADV_MODE_BIT  7
`define MCFG_ADV_SHIFT_LSB 4
`define MCFG_ADV_MANT_LSB  0
`define MCFG_STAT_LSB      6
`define MCFG_ANGLE_LSB     4
`define MCFG_ISD_EN_BIT    3
`define MCFG_BWD_EN_BIT    2
`define MCFG_BWD_THR_LSB   0
`define MCFG_OLCUR_LSB     6
`define MCFG_OLRAMP_LSB    3
`define MCFG_BRAKE_LSB     0
`define MCFG_GAIN_LSB      6
`define MCFG_ACC2_LSB      3
`define MCFG_ACC1_LSB      0
`define MCFG_HAND_LSB      3
`define MCFG_HAND_RANGE_BIT 7
`define MCFG_ALIGN_LSB     0
`define MCFG_FAULT_EN_LSB  4
`define MCFG_IND_CLAMP_BIT 3
`define MCFG_MECH_EN_BIT   2
`define MCFG_MECH_TGT_BIT  1
`define MCFG_RELEASE_BIT   0

// ----------------------------------------
// Timing
// ----------------------------------------
`define MCFG_CLK_PERIOD_NS 10
`define MCFG_ADV_UNIT_NS   2500
`define MCFG_ADV_UNIT_CYC  (`MCFG_ADV_UNIT_NS / `MCFG_CLK_PERIOD_NS)
`define MCFG_ISD_BASE_MS   80
`define MCFG_ISD_BASE_CYC  ((`MCFG_ISD_BASE_MS * 1000000) / `MCFG_CLK_PERIOD_NS)

`endif

// *** mcfg_pkg.sv ***
// Types of the start-up configuration bank.
package mcfg_pkg;

  typedef struct packed {
    logic [7:0] advance;
    logic [7:0] speedDet;
    logic [7:0] openLoop;
    logic [7:0] startup;
    logic [7:0] handover;
    logic [7:0] fault;
  } mcfg_regs_t;

  typedef struct packed {
    mcfg_regs_t  regs;
    logic [7:0]  readData;
    logic [25:0] stationaryCycles;
    logic [6:0]  stationaryDhz;
    logic [6:0]  angleDeg;
    logic [8:0]  backwardDhz;
    logic [10:0] currentMa;
    logic [12:0] rampMilliVcc;
    logic        brakeEn;
    logic [11:0] brakeMs;
    logic [2:0]  gainQuarters;
    logic [12:0] accel2CentiHz;
    logic [9:0]  accel1DeciHz;
    logic [12:0] handoverDhz;
    logic        handoverValid;
    logic [12:0] alignMs;
  } mcfg_bank_state_t;

  typedef struct packed {
    logic [18:0] advanceCycles;
    logic [10:0] advanceUnits;
  } mcfg_adv_state_t;

endpackage : mcfg_pkg

// *** mcfg_advance_calc.sv ***
// Commutation advance time calculator: shifted mantissa scaled to clock cycles.
`timescale 1ns/1ps
`include "mcfg_defines.svh"

module mcfg_advance_calc #(
  parameter int UNIT_CYCLES = `MCFG_ADV_UNIT_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Raw advance field
  input  wire logic [6:0]  advanceField,
  // Decoded advance time
  output logic      [10:0] advanceUnits,
  output logic      [18:0] advanceCycles
);

  mcfg_pkg::mcfg_adv_state_t stateReg;
  mcfg_pkg::mcfg_adv_state_t stateNext;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [10:0] units;
    units = 11'h000;
    units = 11'(advanceField[`MCFG_ADV_MANT_LSB +: 4]) << advanceField[`MCFG_ADV_SHIFT_LSB +: 3];
    stateNext.advanceUnits  = units;
    stateNext.advanceCycles = 19'(units * UNIT_CYCLES);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign advanceUnits  = stateReg.advanceUnits;
  assign advanceCycles = stateReg.advanceCycles;

endmodule : mcfg_advance_calc

// *** mcfg_config_bank.sv ***
// Start-up configuration register bank with decoded fields for the motor control core.
`timescale 1ns/1ps
`include "mcfg_defines.svh"

module mcfg_config_bank #(
  parameter int STATIONARY_BASE_CYCLES = `MCFG_ISD_BASE_CYC,
  parameter int ADVANCE_UNIT_CYCLES    = `MCFG_ADV_UNIT_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regWriteData,
  output logic      [7:0]  regReadData,
  output logic             regHit,
  // Commutation advance
  output logic             advanceMethodSel,
  output logic      [6:0]  advanceTimeField,
  output logic      [10:0] advanceTimeUnits,
  output logic      [18:0] advanceTimeCycles,
  // Initial speed and backward drive
  output logic      [1:0]  stationaryThreshold,
  output logic      [25:0] stationaryTimeoutCycles,
  output logic      [6:0]  stationarySpeedDhz,
  output logic      [1:0]  postSenseAdvanceAngle,
  output logic      [6:0]  postSenseAngleDeg,
  output logic             initialSpeedDetectEn,
  output logic             backwardDriveEn,
  output logic      [1:0]  backwardDriveThreshold,
  output logic      [8:0]  backwardDriveSpeedDhz,
  // Open loop and braking
  output logic      [1:0]  openLoopCurrentSel,
  output logic      [10:0] openLoopCurrentMa,
  output logic      [2:0]  openLoopRampRate,
  output logic      [12:0] openLoopRampMilliVcc,
  output logic      [2:0]  brakeDurationSel,
  output logic             brakeEn,
  output logic      [11:0] brakeDurationMs,
  // Start-up profile
  output logic      [1:0]  loopGainSel,
  output logic      [2:0]  loopGainQuarters,
  output logic      [2:0]  startupAccelSecondOrder,
  output logic      [12:0] startupAccelSecondCentiHz,
  output logic      [2:0]  startupAccelFirstOrder,
  output logic      [9:0]  startupAccelFirstDeciHz,
  output logic      [4:0]  loopHandoverSpeed,
  output logic      [12:0] loopHandoverDhz,
  output logic             loopHandoverValid,
  output logic      [2:0]  alignDurationSel,
  output logic      [12:0] alignDurationMs,
  // Faults and clamping
  output logic      [3:0]  faultDetectEnables,
  output logic             inductiveClampEn,
  output logic             mechanicalClampEn,
  output logic             mechanicalClampTarget,
  output logic             senseReleaseMode
);

  mcfg_pkg::mcfg_bank_state_t stateReg;
  mcfg_pkg::mcfg_bank_state_t stateNext;

  // ----------------------------------------
  // Lookup tables
  // ----------------------------------------
  function automatic logic [6:0] statDhz(input logic [1:0] c);
    case (c)
      2'h0:    statDhz = 7'h3C;
      2'h1:    statDhz = 7'h1E;
      2'h2:    statDhz = 7'h10;
      default: statDhz = 7'h08;
    endcase
  endfunction : statDhz

  function automatic logic [8:0] bwdDhz(input logic [1:0] c);
    case (c)
      2'h0:    bwdDhz = 9'h03F;
      2'h1:    bwdDhz = 9'h082;
      2'h2:    bwdDhz = 9'h104;
      default: bwdDhz = 9'h1FE;
    endcase
  endfunction : bwdDhz

  function automatic logic [12:0] rampMv(input logic [2:0] c);
    case (c)
      3'h0:    rampMv = 13'h1770;
      3'h1:    rampMv = 13'h0BB8;
      3'h2:    rampMv = 13'h05DC;
      3'h3:    rampMv = 13'h02BC;
      3'h4:    rampMv = 13'h0154;
      3'h5:    rampMv = 13'h00A0;
      3'h6:    rampMv = 13'h0046;
      default: rampMv = 13'h0017;
    endcase
  endfunction : rampMv

  // Align uses the same halving ladder as braking, one step longer.
  function automatic logic [12:0] ladderMs(input logic [3:0] c);
    case (c)
      4'h0:    ladderMs = 13'h14B4;
      4'h1:    ladderMs = 13'h0A8C;
      4'h2:    ladderMs = 13'h0514;
      4'h3:    ladderMs = 13'h029E;
      4'h4:    ladderMs = 13'h014A;
      4'h5:    ladderMs = 13'h00A0;
      4'h6:    ladderMs = 13'h0050;
      4'h7:    ladderMs = 13'h0028;
      default: ladderMs = 13'h0000;
    endcase
  endfunction : ladderMs

  function automatic logic [12:0] acc2(input logic [2:0] c);
    case (c)
      3'h0:    acc2 = 13'h1644;
      3'h1:    acc2 = 13'h0B54;
      3'h2:    acc2 = 13'h0578;
      3'h3:    acc2 = 13'h02B2;
      3'h4:    acc2 = 13'h014A;
      3'h5:    acc2 = 13'h00A0;
      3'h6:    acc2 = 13'h0042;
      default: acc2 = 13'h0016;
    endcase
  endfunction : acc2

  function automatic logic [9:0] acc1(input logic [2:0] c);
    case (c)
      3'h0:    acc1 = 10'h2F8;
      3'h1:    acc1 = 10'h17C;
      3'h2:    acc1 = 10'h0BE;
      3'h3:    acc1 = 10'h05C;
      3'h4:    acc1 = 10'h02D;
      3'h5:    acc1 = 10'h015;
      3'h6:    acc1 = 10'h009;
      default: acc1 = 10'h003;
    endcase
  endfunction : acc1

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    mcfg_pkg::mcfg_regs_t r;
    logic [3:0] handN;
    stateNext = stateReg;
    r         = stateReg.regs;
    handN     = 4'h0;

    if (regWrite) begin
      case (regAddr)
        `MCFG_ADVANCE_OFS:  r.advance  = regWriteData;
        `MCFG_SPEEDDET_OFS: r.speedDet = regWriteData;
        `MCFG_OPENLOOP_OFS: r.openLoop = regWriteData;
        `MCFG_STARTUP_OFS:  r.startup  = regWriteData;
        `MCFG_HANDOVER_OFS: r.handover = regWriteData;
        `MCFG_FAULT_OFS:    r.fault    = regWriteData;
        default:            r          = stateReg.regs;
      endcase
    end
    stateNext.regs = r;

    if (regRead) begin
      case (regAddr)
        `MCFG_ADVANCE_OFS:  stateNext.readData = stateReg.regs.advance;
        `MCFG_SPEEDDET_OFS: stateNext.readData = stateReg.regs.speedDet;
        `MCFG_OPENLOOP_OFS: stateNext.readData = stateReg.regs.openLoop;
        `MCFG_STARTUP_OFS:  stateNext.readData = stateReg.regs.startup;
        `MCFG_HANDOVER_OFS: stateNext.readData = stateReg.regs.handover;
        `MCFG_FAULT_OFS:    stateNext.readData = stateReg.regs.fault;
        default:            stateNext.readData = 8'h00;
      endcase
    end

    stateNext.stationaryCycles = 26'(STATIONARY_BASE_CYCLES) << r.speedDet[`MCFG_STAT_LSB +: 2];
    stateNext.stationaryDhz    = statDhz(r.speedDet[`MCFG_STAT_LSB +: 2]);

    stateNext.angleDeg = 7'(({5'h00, r.speedDet[`MCFG_ANGLE_LSB +: 2]} + 7'h01) * 7'h1E);

    stateNext.backwardDhz = bwdDhz(r.speedDet[`MCFG_BWD_THR_LSB +: 2]);

    stateNext.currentMa = 11'h0C8 << r.openLoop[`MCFG_OLCUR_LSB +: 2];

    stateNext.rampMilliVcc = rampMv(r.openLoop[`MCFG_OLRAMP_LSB +: 3]);

    stateNext.brakeEn = (r.openLoop[`MCFG_BRAKE_LSB +: 3] != 3'h0);
    stateNext.brakeMs = stateNext.brakeEn ? 12'(ladderMs({1'b0, r.openLoop[`MCFG_BRAKE_LSB +: 3]})) : 12'h000;

    stateNext.gainQuarters = {1'b0, r.startup[`MCFG_GAIN_LSB +: 2]} + 3'h1;

    stateNext.accel2CentiHz = acc2(r.startup[`MCFG_ACC2_LSB +: 3]);

    stateNext.accel1DeciHz = acc1(r.startup[`MCFG_ACC1_LSB +: 3]);

    handN = r.handover[`MCFG_HAND_LSB +: 4];
    if (r.handover[`MCFG_HAND_RANGE_BIT]) begin
      stateNext.handoverDhz   = 13'(({9'h000, handN} + 13'h0001) * 13'h0080);
      stateNext.handoverValid = 1'b1;
    end else begin
      stateNext.handoverDhz   = 13'({9'h000, handN} * 13'h0008);
      stateNext.handoverValid = (handN != 4'h0);
    end

    stateNext.alignMs = ladderMs({1'b0, r.handover[`MCFG_ALIGN_LSB +: 3]});
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stateReg                    <= '0;
      stateReg.regs.advance       <= `MCFG_ADVANCE_RST;
      stateReg.regs.speedDet      <= `MCFG_SPEEDDET_RST;
      stateReg.regs.openLoop      <= `MCFG_OPENLOOP_RST;
      stateReg.regs.startup       <= `MCFG_STARTUP_RST;
      stateReg.regs.handover      <= `MCFG_HANDOVER_RST;
      stateReg.regs.fault         <= `MCFG_FAULT_RST;
      stateReg.stationaryCycles   <= 26'(STATIONARY_BASE_CYCLES);
      stateReg.stationaryDhz      <= 7'h3C;
      stateReg.angleDeg           <= 7'h1E;
      stateReg.backwardDhz        <= 9'h03F;
      stateReg.currentMa          <= 11'h0C8;
      stateReg.rampMilliVcc       <= 13'h1770;
      stateReg.gainQuarters       <= 3'h1;
      stateReg.accel2CentiHz      <= 13'h1644;
      stateReg.accel1DeciHz       <= 10'h2F8;
      stateReg.alignMs            <= 13'h14B4;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ----------------------------------------
  // Advance time
  // ----------------------------------------
  // Fed from the next register value so the decoded time lands with the register.
  mcfg_advance_calc #(
    .UNIT_CYCLES (ADVANCE_UNIT_CYCLES)
  ) advanceCalc (
    .clock         (clock),
    .reset         (reset),
    .advanceField  (stateNext.regs.advance[6:0]),
    .advanceUnits  (advanceTimeUnits),
    .advanceCycles (advanceTimeCycles)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign regReadData = stateReg.readData;
  assign regHit      = (regAddr >= `MCFG_ADVANCE_OFS) && (regAddr <= `MCFG_FAULT_OFS);

  assign advanceMethodSel = stateReg.regs.advance[`MCFG_ADV_MODE_BIT];
  assign advanceTimeField = stateReg.regs.advance[6:0];

  assign stationaryThreshold     = stateReg.regs.speedDet[`MCFG_STAT_LSB +: 2];
  assign stationaryTimeoutCycles = stateReg.stationaryCycles;
  assign stationarySpeedDhz      = stateReg.stationaryDhz;
  assign postSenseAdvanceAngle   = stateReg.regs.speedDet[`MCFG_ANGLE_LSB +: 2];
  assign postSenseAngleDeg       = stateReg.angleDeg;
  assign initialSpeedDetectEn    = stateReg.regs.speedDet[`MCFG_ISD_EN_BIT];
  assign backwardDriveEn         = stateReg.regs.speedDet[`MCFG_BWD_EN_BIT];
  assign backwardDriveThreshold  = stateReg.regs.speedDet[`MCFG_BWD_THR_LSB +: 2];
  assign backwardDriveSpeedDhz   = stateReg.backwardDhz;

  assign openLoopCurrentSel   = stateReg.regs.openLoop[`MCFG_OLCUR_LSB +: 2];
  assign openLoopCurrentMa    = stateReg.currentMa;
  assign openLoopRampRate     = stateReg.regs.openLoop[`MCFG_OLRAMP_LSB +: 3];
  assign openLoopRampMilliVcc = stateReg.rampMilliVcc;
  assign brakeDurationSel     = stateReg.regs.openLoop[`MCFG_BRAKE_LSB +: 3];
  assign brakeEn              = stateReg.brakeEn;
  assign brakeDurationMs      = stateReg.brakeMs;

  assign loopGainSel               = stateReg.regs.startup[`MCFG_GAIN_LSB +: 2];
  assign loopGainQuarters          = stateReg.gainQuarters;
  assign startupAccelSecondOrder   = stateReg.regs.startup[`MCFG_ACC2_LSB +: 3];
  assign startupAccelSecondCentiHz = stateReg.accel2CentiHz;
  assign startupAccelFirstOrder    = stateReg.regs.startup[`MCFG_ACC1_LSB +: 3];
  assign startupAccelFirstDeciHz   = stateReg.accel1DeciHz;
  assign loopHandoverSpeed         = stateReg.regs.handover[`MCFG_HAND_LSB +: 5];
  assign loopHandoverDhz           = stateReg.handoverDhz;
  assign loopHandoverValid         = stateReg.handoverValid;
  assign alignDurationSel          = stateReg.regs.handover[`MCFG_ALIGN_LSB +: 3];
  assign alignDurationMs           = stateReg.alignMs;

  assign faultDetectEnables    = stateReg.regs.fault[`MCFG_FAULT_EN_LSB +: 4];
  // The inductive clamp bit is stored and shown but drives nothing in the core.
  assign inductiveClampEn      = stateReg.regs.fault[`MCFG_IND_CLAMP_BIT];
  assign mechanicalClampEn     = stateReg.regs.fault[`MCFG_MECH_EN_BIT];
  assign mechanicalClampTarget = stateReg.regs.fault[`MCFG_MECH_TGT_BIT];
  assign senseReleaseMode      = stateReg.regs.fault[`MCFG_RELEASE_BIT];

endmodule : mcfg_config_bank

// *** mcfg_config_bank_chk.sv ***
// Concurrent checks on the ports of the start-up configuration bank.
`timescale 1ns/1ps
`include "mcfg_defines.svh"

module mcfg_config_bank_chk #(
  parameter int STATIONARY_BASE_CYCLES = `MCFG_ISD_BASE_CYC
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // Register port
  input wire logic [7:0]  regAddr,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regWriteData,
  input wire logic [7:0]  regReadData,
  input wire logic        regHit,
  // Decoded fields
  input wire logic        advanceMethodSel,
  input wire logic [10:0] advanceTimeUnits,
  input wire logic [1:0]  stationaryThreshold,
  input wire logic [25:0] stationaryTimeoutCycles,
  input wire logic [1:0]  postSenseAdvanceAngle,
  input wire logic [6:0]  postSenseAngleDeg,
  input wire logic        initialSpeedDetectEn,
  input wire logic        backwardDriveEn,
  input wire logic [1:0]  openLoopCurrentSel,
  input wire logic [10:0] openLoopCurrentMa,
  input wire logic [2:0]  brakeDurationSel,
  input wire logic        brakeEn,
  input wire logic [4:0]  loopHandoverSpeed,
  input wire logic        loopHandoverValid,
  input wire logic [3:0]  faultDetectEnables
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  adv_mode_a: assert property (regWrite && regAddr == 8'h22 |=> advanceMethodSel == $past(regWriteData[7]))
    else $error("advance method not taken from bit 7");
  adv_units_a: assert property (regWrite && regAddr == 8'h22 |=>
    advanceTimeUnits == (11'($past(regWriteData[3:0])) << $past(regWriteData[6:4])))
    else $error("advance units not mantissa shifted");
  stat_time_a: assert property (stationaryTimeoutCycles == (26'(STATIONARY_BASE_CYCLES) << stationaryThreshold))
    else $error("stationary timeout wrong");
  angle_deg_a: assert property (postSenseAngleDeg == 7'(postSenseAdvanceAngle) * 7'h1E + 7'h1E)
    else $error("post sense angle wrong");
  speed_en_a: assert property (regWrite && regAddr == 8'h23 |=>
    {initialSpeedDetectEn, backwardDriveEn} == $past(regWriteData[3:2]))
    else $error("speed detect or backward enable wrong");
  ol_current_a: assert property (openLoopCurrentMa == (11'h0C8 << openLoopCurrentSel))
    else $error("open loop current wrong");
  brake_en_a: assert property (brakeEn == (brakeDurationSel != 3'h0))
    else $error("brake enable wrong");
  handover_ok_a: assert property (loopHandoverValid == (loopHandoverSpeed != 5'h00))
    else $error("handover valid wrong");
  fault_hold_a: assert property (!(regWrite && regAddr == 8'h27) |=> $stable(faultDetectEnables))
    else $error("fault enables changed without a write");
  unmap_read_a: assert property (regRead && !regHit |=> regReadData == 8'h00)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!regRead |=> $stable(regReadData))
    else $error("read data changed without a read");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  cover property (regWrite && regAddr == 8'h22);
  cover property (regRead && !regHit);
  cover property (regWrite && regRead && regAddr == 8'h24);
endmodule : mcfg_config_bank_chk

bind mcfg_config_bank mcfg_config_bank_chk #(.STATIONARY_BASE_CYCLES(STATIONARY_BASE_CYCLES)) chk (
  .clock, .reset, .regAddr, .regWrite, .regRead, .regWriteData, .regReadData, .regHit,
  .advanceMethodSel, .advanceTimeUnits, .stationaryThreshold, .stationaryTimeoutCycles,
  .postSenseAdvanceAngle, .postSenseAngleDeg, .initialSpeedDetectEn, .backwardDriveEn,
  .openLoopCurrentSel, .openLoopCurrentMa, .brakeDurationSel, .brakeEn, .loopHandoverSpeed,
  .loopHandoverValid, .faultDetectEnables);

// *** mcfg_config_bank_test.sv ***
// Self-checking testbench of the start-up configuration bank.
`timescale 1ns/1ps

module mcfg_config_bank_test;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWriteData = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regReadData;
  logic        regHit, advanceMethodSel, initialSpeedDetectEn, backwardDriveEn, brakeEn, loopHandoverValid;
  logic        inductiveClampEn, mechanicalClampEn, mechanicalClampTarget, senseReleaseMode;
  logic [1:0]  stationaryThreshold, postSenseAdvanceAngle, backwardDriveThreshold, openLoopCurrentSel, loopGainSel;
  logic [2:0]  openLoopRampRate, brakeDurationSel, loopGainQuarters, alignDurationSel;
  logic [2:0]  startupAccelSecondOrder, startupAccelFirstOrder;
  logic [3:0]  faultDetectEnables;
  logic [4:0]  loopHandoverSpeed;
  logic [6:0]  advanceTimeField, stationarySpeedDhz, postSenseAngleDeg;
  logic [8:0]  backwardDriveSpeedDhz;
  logic [9:0]  startupAccelFirstDeciHz;
  logic [10:0] advanceTimeUnits, openLoopCurrentMa;
  logic [11:0] brakeDurationMs;
  logic [12:0] openLoopRampMilliVcc, startupAccelSecondCentiHz, loopHandoverDhz, alignDurationMs;
  logic [18:0] advanceTimeCycles;
  logic [25:0] stationaryTimeoutCycles;
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;

  // ----------------------------------------
  // Expected decode tables
  // ----------------------------------------
  logic [6:0]  statT [4] = '{7'h3C, 7'h1E, 7'h10, 7'h08};
  logic [6:0]  angT [4] = '{7'h1E, 7'h3C, 7'h5A, 7'h78};
  logic [8:0]  bwdT [4] = '{9'h03F, 9'h082, 9'h104, 9'h1FE};
  logic [10:0] curT [4] = '{11'h0C8, 11'h190, 11'h320, 11'h640};
  logic [12:0] rampT [8] = '{13'h1770, 13'h0BB8, 13'h05DC, 13'h02BC, 13'h0154, 13'h00A0, 13'h0046, 13'h0017};
  logic [11:0] brkT [8] = '{12'h000, 12'hA8C, 12'h514, 12'h29E, 12'h14A, 12'h0A0, 12'h050, 12'h028};
  logic [12:0] acc2T [8] = '{13'h1644, 13'h0B54, 13'h0578, 13'h02B2, 13'h014A, 13'h00A0, 13'h0042, 13'h0016};
  logic [9:0]  acc1T [8] = '{10'h2F8, 10'h17C, 10'h0BE, 10'h05C, 10'h02D, 10'h015, 10'h009, 10'h003};
  logic [12:0] alnT [8] = '{13'h14B4, 13'h0A8C, 13'h0514, 13'h029E, 13'h014A, 13'h00A0, 13'h0050, 13'h0028};
  logic [4:0]  hoT [8] = '{5'h00, 5'h01, 5'h02, 5'h0F, 5'h10, 5'h11, 5'h1E, 5'h1F};

  // A small base keeps the stationary timeout count short in simulation.
  mcfg_config_bank #(.STATIONARY_BASE_CYCLES(16)) uut (
    .clock, .reset, .regAddr, .regWrite, .regRead, .regWriteData, .regReadData, .regHit,
    .advanceMethodSel, .advanceTimeField, .advanceTimeUnits, .advanceTimeCycles, .stationaryThreshold,
    .stationaryTimeoutCycles, .stationarySpeedDhz, .postSenseAdvanceAngle, .postSenseAngleDeg,
    .initialSpeedDetectEn, .backwardDriveEn, .backwardDriveThreshold, .backwardDriveSpeedDhz,
    .openLoopCurrentSel, .openLoopCurrentMa, .openLoopRampRate, .openLoopRampMilliVcc, .brakeDurationSel,
    .brakeEn, .brakeDurationMs, .loopGainSel, .loopGainQuarters, .startupAccelSecondOrder,
    .startupAccelSecondCentiHz, .startupAccelFirstOrder, .startupAccelFirstDeciHz, .loopHandoverSpeed,
    .loopHandoverDhz, .loopHandoverValid, .alignDurationSel, .alignDurationMs, .faultDetectEnables,
    .inductiveClampEn, .mechanicalClampEn, .mechanicalClampTarget, .senseReleaseMode);

  always #5 clock = ~clock;

  // ----------------------------------------
  // Bus and report tasks
  // ----------------------------------------
  task automatic results;
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic ck(input bit ok, input string m);
    checked++;
    if (!ok) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : ck

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    ck(regReadData === e, "read data");
  endtask : rd

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int a = 8'h22; a <= 8'h27; a++) rd(8'(a), 8'h00);
    ck(stationaryTimeoutCycles === 26'h10 && postSenseAngleDeg === 7'h1E && openLoopCurrentMa === 11'h0C8
       && alignDurationMs === 13'h14B4 && brakeEn === 1'b0 && loopHandoverValid === 1'b0, "reset decode");
  endtask : t_reset

  task automatic t_adv;
    wr(8'h22, 8'hB5);
    ck(advanceMethodSel === 1'b1 && advanceTimeField === 7'h35, "advance fields");
    ck(advanceTimeUnits === 11'h028 && advanceTimeCycles === 19'h02710, "advance small");
    wr(8'h22, 8'h7F);
    ck(advanceMethodSel === 1'b0 && advanceTimeUnits === 11'h780 && advanceTimeCycles === 19'h75300, "advance max");
    rd(8'h22, 8'h7F);
  endtask : t_adv

  task automatic t_spd;
    for (int i = 0; i < 4; i++) begin
      wr(8'h23, {2'(i), 2'(i), i[0], ~i[0], 2'(i)});
      ck(stationaryThreshold === 2'(i) && stationaryTimeoutCycles === (26'h10 << i)
         && stationarySpeedDhz === statT[i], "stationary");
      ck(postSenseAdvanceAngle === 2'(i) && postSenseAngleDeg === angT[i], "angle");
      ck(initialSpeedDetectEn === i[0] && backwardDriveEn === ~i[0], "speed enables");
      ck(backwardDriveThreshold === 2'(i) && backwardDriveSpeedDhz === bwdT[i], "backward threshold");
    end
  endtask : t_spd

  task automatic t_ol;
    for (int i = 0; i < 8; i++) begin
      wr(8'h24, {2'(i), 3'(i), 3'(7 - i)});
      ck(openLoopCurrentSel === 2'(i) && openLoopCurrentMa === curT[i % 4], "current");
      ck(openLoopRampRate === 3'(i) && openLoopRampMilliVcc === rampT[i], "ramp");
      ck(brakeDurationSel === 3'(7 - i) && brakeEn === (i != 7) && brakeDurationMs === brkT[7 - i], "brake");
    end
  endtask : t_ol

  task automatic t_st;
    for (int i = 0; i < 8; i++) begin
      wr(8'h25, {2'(i), 3'(i), 3'(7 - i)});
      ck(loopGainSel === 2'(i) && loopGainQuarters === 3'(i % 4 + 1), "gain");
      ck(startupAccelSecondOrder === 3'(i) && startupAccelSecondCentiHz === acc2T[i], "accel2");
      ck(startupAccelFirstOrder === 3'(7 - i) && startupAccelFirstDeciHz === acc1T[7 - i], "accel1");
    end
  endtask : t_st

  task automatic t_ho;
    logic [4:0] c;
    for (int i = 0; i < 8; i++) begin
      c = hoT[i];
      wr(8'h26, {c, 3'(i)});
      ck(loopHandoverSpeed === c && loopHandoverValid === (c != 5'h00) && loopHandoverDhz === (c[4] ?
         (({9'h000, c[3:0]} + 13'h0001) << 7) : ({9'h000, c[3:0]} << 3)), "handover");
      ck(alignDurationSel === 3'(i) && alignDurationMs === alnT[i], "align");
    end
  endtask : t_ho

  task automatic t_flt;
    for (int i = 0; i < 8; i++) begin
      wr(8'h27, (8'h01 << i) & 8'hF7);
      ck({faultDetectEnables, inductiveClampEn, mechanicalClampEn, mechanicalClampTarget, senseReleaseMode}
         === ((8'h01 << i) & 8'hF7), "fault and clamp bits");
    end
    wr(8'h27, 8'hF7);
    rd(8'h27, 8'hF7);
  endtask : t_flt

  task automatic t_map;
    wr(8'h21, 8'hFF);
    wr(8'h28, 8'hFF);
    rd(8'h21, 8'h00);
    ck(regHit === 1'b0, "hit low");
    rd(8'h28, 8'h00);
    rd(8'h22, 8'h7F);
    ck(regHit === 1'b1, "hit high");
    // Write and read together at one edge must return the value from before the write.
    @(negedge clock);
    regAddr = 8'h24;
    regWriteData = 8'h5A;
    regWrite = 1'b1;
    regRead = 1'b1;
    @(negedge clock);
    regAddr = 8'h25;
    regWriteData = 8'h40;
    regRead = 1'b0;
    ck(regReadData === 8'hF8, "old value");
    @(negedge clock);
    regWrite = 1'b0;
    ck(loopGainQuarters === 3'h2 && openLoopCurrentSel === 2'h1 && brakeEn === 1'b1, "back to back");
    rd(8'h24, 8'h5A);
  endtask : t_map

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    repeat (10) @(negedge clock);
    reset = 1'b0;
    t_reset();
    t_adv();
    t_spd();
    t_ol();
    t_st();
    t_ho();
    t_flt();
    t_map();
    results();
  end
endmodule : mcfg_config_bank_test
